// *** tcp_consts.svh ***
// register map, field positions and counts of the test-pattern control block
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH
`define TCP_ADDR_CTRL 8'h06
`define TCP_ADDR_HOLD 8'h07
`define TCP_ADDR_ERR_MSB 8'h0c
`define TCP_ADDR_ERR_LSB 8'h0d
`define TCP_CTRL_RESET 8'h00
`define TCP_BIT_CLEAR_CH 7
`define TCP_BIT_OH_SERIAL 6
`define TCP_BIT_UNUSED 5
`define TCP_BIT_ENABLE 4
`define TCP_BIT_SPARE 3
`define TCP_BIT_BURST 2
`define TCP_BIT_DONE 1
`define TCP_BIT_SYNC 0
`define TCP_CELL_BITS 384
`define TCP_BURST_CELLS 1024
`define TCP_LOCK_RUN 32
`define TCP_LOSS_RUN 8
`define TCP_PRBS_SEED 15'h7fff
`endif

// *** tcp_pkg.sv ***
// types and the shared pattern polynomial of the test-pattern block
package tcp_pkg;
  typedef enum logic [0:0] {
    TCP_IDLE = 1'b0,
    TCP_RUN = 1'b1
  } tcp_burst_t;
  // x^15 + x^14 + 1, used by both generator and checker
  function automatic logic tcp_prbs_fb(input logic [14:0] s);
    tcp_prbs_fb = s[14] ^ s[13];
  endfunction : tcp_prbs_fb
endpackage : tcp_pkg

// *** tcp_checker.sv ***
// self-synchronising pattern checker with lock and loss-of-lock hunting
`include "tcp_consts.svh"
module tcp_checker #(
  parameter int LOCK_RUN = `TCP_LOCK_RUN,
  parameter int LOSS_RUN = `TCP_LOSS_RUN
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // received stream
  input wire logic hunt_clear,
  input wire logic bit_en,
  input wire logic bit_in,
  // results
  output logic locked_q,
  output logic err_q
);
  logic [14:0] shr_q, shr_d;
  logic [7:0] run_q, run_d;
  logic locked_d, err_d, miss;

  assign miss = tcp_pkg::tcp_prbs_fb(shr_q) != bit_in;

  // received bits seed the predictor, so lock needs no alignment search
  always_comb begin
    shr_d = shr_q;
    run_d = run_q;
    locked_d = locked_q;
    err_d = 1'b0;
    if (hunt_clear) begin
      run_d = 8'h00;
      locked_d = 1'b0;
    end else if (bit_en) begin
      shr_d = {shr_q[13:0], bit_in};
      if (!locked_q) begin
        run_d = miss ? 8'h00 : run_q + 8'h01;
        if (!miss && run_q == 8'(LOCK_RUN - 1)) begin
          locked_d = 1'b1;
          run_d = 8'h00;
        end
      end else begin
        err_d = miss;
        run_d = miss ? run_q + 8'h01 : 8'h00;
        if (miss && run_q == 8'(LOSS_RUN - 1)) begin
          locked_d = 1'b0;
          run_d = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shr_q <= 15'h0000;
      run_q <= 8'h00;
      locked_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      shr_q <= shr_d;
      run_q <= run_d;
      locked_q <= locked_d;
      err_q <= err_d;
    end
  end

  // errors only ever reported while locked
  err_locked_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) err_q |-> $past(locked_q))
    else $error("error before lock");
endmodule : tcp_checker

// *** tcp_test_pattern.sv ***
// test-cell / raw pattern unit: control register, generator, error total
`include "tcp_consts.svh"
module tcp_test_pattern #(
  parameter int CELL_BITS = `TCP_CELL_BITS,
  parameter int BURST_CELLS = `TCP_BURST_CELLS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // microprocessor port
  input wire logic cpu_cs,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_bus_8bit,
  output logic [7:0] cpu_rdata_q,
  output logic [15:0] cpu_rdata16_q,
  // transmit side
  input wire logic tx_bit_en,
  output logic tx_pattern_bit_q,
  output logic tx_pattern_valid_q,
  output logic tx_cell_start_q,
  output logic tx_oh_from_serial_q,
  output logic clear_channel_q,
  // receive side
  input wire logic rx_bit_en,
  input wire logic rx_cell_payload_valid,
  input wire logic rx_bit
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q, ctrl_d;
  logic en_prev_q, en_rise;
  tcp_pkg::tcp_burst_t burst_q, burst_d;
  logic done_q, done_d;
  logic [9:0] cell_cnt_q, cell_cnt_d;
  logic [8:0] bit_cnt_q, bit_cnt_d;
  logic [14:0] gen_q, gen_d;
  logic [15:0] acc_q, acc_d;
  logic [7:0] hold_q, hold_d;
  logic [7:0] rdata_d;
  logic [15:0] rdata16_d;
  logic cc, ena, burst_sel, gen_on, cell_end, rd, wr;
  logic rx_take, locked, err;
  logic tx_bit_d, tx_valid_d, tx_start_d;

  assign cc = ctrl_q[`TCP_BIT_CLEAR_CH];
  assign ena = ctrl_q[`TCP_BIT_ENABLE];
  assign burst_sel = ctrl_q[`TCP_BIT_BURST] && !cc;
  assign en_rise = ena && !en_prev_q;
  assign rd = cpu_cs && cpu_rd;
  assign wr = cpu_cs && cpu_wr;
  // continuous runs while enabled, burst only while its count lasts
  assign gen_on = ena && (!burst_sel || burst_q == tcp_pkg::TCP_RUN);
  assign cell_end = tx_bit_en && bit_cnt_q == 9'(CELL_BITS - 1);

  ////////////////////////////////////////////////////////////////////////
  // control register; bit 5 never stores, status bits are not stored here
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && cpu_addr == `TCP_ADDR_CTRL) begin
      ctrl_d = cpu_wdata & 8'hdc;
    end
  end

  // mode pin moves only with a control write, one cycle after it
  mode_follows_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) clear_channel_q == ($past(wr &&
    cpu_addr == `TCP_ADDR_CTRL) ? $past(cpu_wdata[`TCP_BIT_CLEAR_CH]) :
    $past(clear_channel_q))) else $error("mode output stale");
  oh_route_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) tx_oh_from_serial_q |-> !cc && ctrl_q[6])
    else $error("oh route");

  ////////////////////////////////////////////////////////////////////////
  // burst sequencer and burst-complete flag
  always_comb begin
    burst_d = burst_q;
    done_d = done_q;
    cell_cnt_d = cell_cnt_q;
    if (!ena) begin
      burst_d = tcp_pkg::TCP_IDLE;
    end
    case (burst_q)
      tcp_pkg::TCP_IDLE: begin
        if (en_rise && burst_sel) begin
          burst_d = tcp_pkg::TCP_RUN;
          done_d = 1'b0;
          cell_cnt_d = 10'h000;
        end
      end
      tcp_pkg::TCP_RUN: begin
        if (!ena || !burst_sel) begin
          burst_d = tcp_pkg::TCP_IDLE;
        end else if (cell_end) begin
          cell_cnt_d = cell_cnt_q + 10'h001;
          if (cell_cnt_q == 10'(BURST_CELLS - 1)) begin
            burst_d = tcp_pkg::TCP_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: burst_d = tcp_pkg::TCP_IDLE;
    endcase
  end

  // a new burst always starts with the flag low
  done_clear_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) en_rise && burst_sel &&
    burst_q == tcp_pkg::TCP_IDLE |=> !done_q &&
    burst_q == tcp_pkg::TCP_RUN) else $error("burst start");
  // checks the state, not gen_on: a write to continuous may coincide
  burst_stop_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) burst_q == tcp_pkg::TCP_RUN && cell_end &&
    ena && burst_sel && cell_cnt_q == 10'(BURST_CELLS - 1) |=>
    done_q && burst_q == tcp_pkg::TCP_IDLE) else $error("burst end");

  ////////////////////////////////////////////////////////////////////////
  // pattern generator: ATM cells of payload bits, or a raw stream
  always_comb begin
    gen_d = gen_q;
    bit_cnt_d = bit_cnt_q;
    tx_bit_d = tx_pattern_bit_q;
    tx_valid_d = 1'b0;
    tx_start_d = 1'b0;
    if (!gen_on) begin
      bit_cnt_d = 9'h000;
    end else if (tx_bit_en) begin
      tx_bit_d = tcp_pkg::tcp_prbs_fb(gen_q);
      gen_d = {gen_q[13:0], tcp_pkg::tcp_prbs_fb(gen_q)};
      tx_valid_d = 1'b1;
      tx_start_d = !cc && bit_cnt_q == 9'h000;
      bit_cnt_d = cell_end ? 9'h000 : bit_cnt_q + 9'h001;
    end
  end

  // no pattern bit leaves while the enable bit is low
  gen_off_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) !$past(ena) |-> !tx_pattern_valid_q)
    else $error("generator on");

  ////////////////////////////////////////////////////////////////////////
  // receiver hands bits to the checker: test-cell payload or raw stream
  assign rx_take = cc ? rx_bit_en : rx_cell_payload_valid;

  tcp_checker #(
    .LOCK_RUN(`TCP_LOCK_RUN),
    .LOSS_RUN(`TCP_LOSS_RUN)
  ) u_chk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .hunt_clear(!ena),
    .bit_en(rx_take),
    .bit_in(rx_bit),
    .locked_q(locked),
    .err_q(err)
  );

  ////////////////////////////////////////////////////////////////////////
  // error total, cleared by a read; an error in the read cycle still counts
  always_comb begin
    logic rd_acc;
    rd_acc = rd && (cpu_addr == `TCP_ADDR_ERR_MSB ||
                    cpu_addr == `TCP_ADDR_ERR_LSB);
    acc_d = rd_acc ? 16'h0000 : acc_q;
    hold_d = hold_q;
    if (err && acc_d != 16'hffff) begin
      acc_d = acc_d + 16'h0001;
    end
    if (rd_acc && cpu_bus_8bit) begin
      hold_d = (cpu_addr == `TCP_ADDR_ERR_MSB) ? acc_q[7:0] : acc_q[15:8];
    end
  end

  // a high-byte read restarts the total; one error may land with it
  acc_restart_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) rd && cpu_addr == `TCP_ADDR_ERR_MSB |=>
    acc_q <= 16'h0001) else $error("total not restarted");
  hold_park_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) rd && cpu_bus_8bit &&
    cpu_addr == `TCP_ADDR_ERR_MSB |=> hold_q == $past(acc_q[7:0]))
    else $error("holding byte");

  ////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe
  always_comb begin
    rdata_d = cpu_rdata_q;
    rdata16_d = cpu_rdata16_q;
    if (rd) begin
      case (cpu_addr)
        `TCP_ADDR_CTRL: rdata_d = {ctrl_q[7:6], 1'b0, ctrl_q[4:2],
                                   done_q, locked};
        `TCP_ADDR_HOLD: rdata_d = hold_q;
        `TCP_ADDR_ERR_MSB: rdata_d = acc_q[15:8];
        `TCP_ADDR_ERR_LSB: rdata_d = acc_q[7:0];
        default: rdata_d = 8'h00;
      endcase
      rdata16_d = acc_q;
    end
  end

  // the unused bit never reads back as one
  unused_zero_a: assert property (@(posedge sys_clk)
    disable iff (!resetn) $past(rd) && $past(cpu_addr) ==
    `TCP_ADDR_CTRL |-> !cpu_rdata_q[5])
    else $error("bit 5 not zero");

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= `TCP_CTRL_RESET;
      en_prev_q <= 1'b0;
      burst_q <= tcp_pkg::TCP_IDLE;
      done_q <= 1'b0;
      cell_cnt_q <= 10'h000;
      bit_cnt_q <= 9'h000;
      gen_q <= `TCP_PRBS_SEED;
      acc_q <= 16'h0000;
      hold_q <= 8'h00;
      cpu_rdata_q <= 8'h00;
      cpu_rdata16_q <= 16'h0000;
      tx_pattern_bit_q <= 1'b0;
      tx_pattern_valid_q <= 1'b0;
      tx_cell_start_q <= 1'b0;
      tx_oh_from_serial_q <= 1'b0;
      clear_channel_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      en_prev_q <= ena;
      burst_q <= burst_d;
      done_q <= done_d;
      cell_cnt_q <= cell_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      gen_q <= gen_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      cpu_rdata_q <= rdata_d;
      cpu_rdata16_q <= rdata16_d;
      tx_pattern_bit_q <= tx_bit_d;
      tx_pattern_valid_q <= tx_valid_d;
      tx_cell_start_q <= tx_start_d;
      tx_oh_from_serial_q <= ctrl_d[`TCP_BIT_OH_SERIAL] &&
                             !ctrl_d[`TCP_BIT_CLEAR_CH];
      clear_channel_q <= ctrl_d[`TCP_BIT_CLEAR_CH];
    end
  end

endmodule : tcp_test_pattern

// *** test_tcp_test_pattern.sv ***
// self-checking bench for the test-pattern control and status block
module test_tcp_test_pattern;
  timeunit 1ns;
  timeprecision 1ns;
  // short cells and bursts keep the run brief
  localparam int CB = 8;
  localparam int BC = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cpu_cs = 1'b0;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_bus_8bit = 1'b1;
  logic tx_bit_en = 1'b0;
  logic rx_bit_en = 1'b0;
  logic rx_cell_payload_valid = 1'b0;
  logic rx_bit = 1'b0;
  logic [7:0] cpu_rdata_q;
  logic [15:0] cpu_rdata16_q;
  logic tx_pattern_bit_q;
  logic tx_pattern_valid_q;
  logic tx_cell_start_q;
  logic tx_oh_from_serial_q;
  logic clear_channel_q;
  logic loop_cc = 1'b0;
  logic loop_atm = 1'b0;
  logic flip = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int vcnt = 0;
  int scnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock and design
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  tcp_test_pattern #(.CELL_BITS(CB), .BURST_CELLS(BC)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .cpu_cs(cpu_cs), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_bus_8bit(cpu_bus_8bit), .cpu_rdata_q(cpu_rdata_q),
    .cpu_rdata16_q(cpu_rdata16_q), .tx_bit_en(tx_bit_en),
    .tx_pattern_bit_q(tx_pattern_bit_q),
    .tx_pattern_valid_q(tx_pattern_valid_q),
    .tx_cell_start_q(tx_cell_start_q),
    .tx_oh_from_serial_q(tx_oh_from_serial_q),
    .clear_channel_q(clear_channel_q), .rx_bit_en(rx_bit_en),
    .rx_cell_payload_valid(rx_cell_payload_valid), .rx_bit(rx_bit));
  ////////////////////////////////////////////////////////////////////////////
  // loopback of generated bits; flip inverts exactly one of them
  always @(negedge sys_clk) begin
    rx_bit_en <= loop_cc & tx_pattern_valid_q;
    rx_cell_payload_valid <= loop_atm & tx_pattern_valid_q;
    rx_bit <= tx_pattern_bit_q ^ (flip & tx_pattern_valid_q);
    if (tx_pattern_valid_q === 1'b1) flip <= 1'b0;
  end
  // count generated bits and cell starts mid-cycle, where pulses are settled
  always @(negedge sys_clk) begin
    if (tx_pattern_valid_q === 1'b1) vcnt <= vcnt + 1;
    if (tx_cell_start_q === 1'b1) scnt <= scnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one write strobe, released after the taking edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    {cpu_cs, cpu_wr, cpu_addr, cpu_wdata} = {2'b11, a, d};
    @(negedge sys_clk);
    {cpu_cs, cpu_wr} = 2'b00;
  endtask : wr
  // one read strobe; data is settled by the following falling edge
  task automatic rc(input logic [7:0] a, exp, input string nm);
    @(negedge sys_clk);
    {cpu_cs, cpu_rd, cpu_addr} = {2'b11, a};
    @(negedge sys_clk);
    {cpu_cs, cpu_rd} = 2'b00;
    chk(nm, {8'h00, cpu_rdata_q}, {8'h00, exp});
  endtask : rc
  // n outbound bit slots, then let the pipeline drain
  task automatic pump(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      tx_bit_en = 1'b1;
      @(negedge sys_clk);
      tx_bit_en = 1'b0;
    end
    repeat (6) @(negedge sys_clk);
  endtask : pump
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the fewer than 700 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    close_out();
  end
  // test sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    rc(8'h06, 8'h00, "ctrl reset");
    wr(8'h06, 8'hff);
    rc(8'h06, 8'hdc, "ctrl all ones");
    chk("clear channel", {15'h0, clear_channel_q}, 16'h1);
    chk("oh serial cc", {15'h0, tx_oh_from_serial_q}, 16'h0);
    wr(8'h06, 8'h40);
    wr(8'h05, 8'hff);
    rc(8'h06, 8'h40, "ctrl kept");
    chk("oh serial atm", {15'h0, tx_oh_from_serial_q}, 16'h1);
    chk("atm mode", {15'h0, clear_channel_q}, 16'h0);
    rc(8'h01, 8'h00, "unmapped read");
    $display("test register done");
    wr(8'h06, 8'h04);
    wr(8'h06, 8'h14);
    rc(8'h06, 8'h14, "done in burst");
    vcnt = 0;
    scnt = 0;
    pump(BC * CB + 10);
    chk("burst bits", 16'(vcnt), 16'(BC * CB));
    chk("burst cells", 16'(scnt), 16'(BC));
    rc(8'h06, 8'h16, "done after burst");
    wr(8'h06, 8'h04);
    wr(8'h06, 8'h14);
    rc(8'h06, 8'h14, "done cleared");
    $display("test burst done");
    wr(8'h06, 8'h10);
    vcnt = 0;
    pump(40);
    chk("continuous bits", 16'(vcnt), 16'd40);
    wr(8'h06, 8'h00);
    vcnt = 0;
    pump(10);
    chk("disabled bits", 16'(vcnt), 16'd0);
    $display("test continuous done");
    // second reset clears any burst state left behind
    resetn = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    loop_atm = 1'b1;
    wr(8'h06, 8'h10);
    pump(80);
    rc(8'h06, 8'h11, "atm lock");
    wr(8'h06, 8'h00);
    rc(8'h06, 8'h00, "lock dropped");
    loop_atm = 1'b0;
    loop_cc = 1'b1;
    // burst select is set but must not cut the clear-channel stream
    wr(8'h06, 8'h94);
    vcnt = 0;
    scnt = 0;
    pump(80);
    rc(8'h06, 8'h95, "cc lock");
    chk("cc cell starts", 16'(scnt), 16'd0);
    chk("cc bits", 16'(vcnt), 16'd80);
    rc(8'h0c, 8'h00, "total high pre");
    rc(8'h07, 8'h00, "hold pre");
    // a single inverted bit shows three times in a self-syncing checker
    #5 flip = 1'b1;
    pump(30);
    rc(8'h0c, 8'h00, "total high");
    chk("total word", cpu_rdata16_q, 16'h0003);
    rc(8'h07, 8'h03, "hold low byte");
    // a wide bus leaves the holding byte alone
    cpu_bus_8bit = 1'b0;
    rc(8'h0d, 8'h00, "total cleared");
    rc(8'h07, 8'h03, "hold kept wide");
    cpu_bus_8bit = 1'b1;
    rc(8'h06, 8'h95, "lock kept");
    $display("test pattern done");
    close_out();
  end
endmodule : test_tcp_test_pattern
